//--- data_memory_indirect_addressing_bench.sv
// Purpose: Self-checking bench for the data memory access unit
// Assumes: Row = write nibble, address, write data, expected read data
// Notes:   Each access made by acc is followed by one idle cycle; the back to back write and read have none
`timescale 1ns/1ps
module data_memory_indirect_addressing_bench import dm_pkg::*;;
    // ----
    // Stimulus and checks
    // ----
    logic clk = 1'b0;
    logic nrst = 1'b0;
    dm_req_type cpu_req = '0;
    dm_rsp_type cpu_rsp;
    dm_sfr_type sfr_bus;
    logic [7:0] sfr_rdata;
    logic sfr_hit;
    logic sfr_read_only;
    int mismatches = 0;
    int comparisons = 0;
    localparam logic [31:0] ROWS [34] = '{32'h1080_AA00, 32'h11F0_5C00, 32'h15FF_3E00,
        32'h0080_00AA, 32'h01F0_005C, 32'h1001_8000, 32'h0001_0080, 32'h0000_00AA,
        32'h1004_0100, 32'h1003_F000, 32'h0002_005C, 32'h100E_0500, 32'h100D_FF00,
        32'h000C_003E, 32'h100C_7700, 32'h05FF_0077, 32'h1001_F000, 32'h1000_1100,
        32'h01F0_005C, 32'h00F0_0011, 32'h1010_C300, 32'h0010_00C3, 32'h100F_9900,
        32'h000F_00A5, 32'h0020_0000, 32'h0110_0000, 32'h16F0_1200, 32'h06F0_0000,
        32'h1001_1000, 32'h0000_00C3, 32'h1000_4D00, 32'h0010_004D,
        32'h1001_0200, 32'h0000_0000};
    localparam logic [11:0] PTRS [6] = '{12'h001, 12'h003, 12'h004, 12'h00D, 12'h00E, 12'h000};
    always #50 clk = ~clk;
    dm_unit #(.NUM_SECTORS(6)) u_dm_unit (.clk(clk), .nrst(nrst), .cpu_req(cpu_req),
        .cpu_rsp(cpu_rsp), .sfr_bus(sfr_bus), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .sfr_read_only(sfr_read_only));
    dm_sfr_model u_dm_sfr_model (.clk(clk), .sfr_bus(sfr_bus), .sfr_rdata(sfr_rdata),
        .sfr_hit(sfr_hit), .sfr_read_only(sfr_read_only));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic acc(input logic [31:0] row);
        @(posedge clk);
        cpu_req <= {1'b1, row[28], row[26:16], row[15:8]};
        @(posedge clk);
        cpu_req.valid <= 1'b0;
        #1;
        if (!row[28]) begin
            chk("rsp valid", {7'h00, cpu_rsp.valid}, 8'h01);
            chk("rdata", cpu_rsp.rdata, row[7:0]);
        end
    endtask
    initial begin
        #1_000_000;
        mismatches++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        foreach (ROWS[i]) acc(ROWS[i]);
        @(posedge clk);
        cpu_req <= {1'b1, 1'b1, 11'h001, 8'h80};
        @(posedge clk);
        cpu_req <= {1'b1, 1'b0, 11'h000, 8'h00};
        @(posedge clk);
        cpu_req.valid <= 1'b0;
        #1 chk("back to back", cpu_rsp.rdata, 8'hAA);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("rsp valid in reset", {7'h00, cpu_rsp.valid}, 8'h00);
        chk("rdata in reset", cpu_rsp.rdata, 8'h00);
        nrst <= 1'b1;
        foreach (PTRS[i]) acc({4'h0, PTRS[i], 16'h0000});
        final_report();
    end
endmodule

//--- dm_pkg.sv
// Purpose: Shared constants and carrier types for the data memory access unit
// Assumes: 8-bit data, 11-bit extended data memory address (sector in high part)
// Notes:   Special purpose region is 00H..7FH of each of the NUM_SECTORS sectors, RAM is 80H..FFH; higher sectors read zero
package dm_pkg;

    // ----------------------------------------------------------------
    // Address layout
    // ----------------------------------------------------------------
    localparam int DM_ADDR_W = 11;
    localparam int DM_LOC_W = 8;
    localparam int DM_SEC_W = 3;
    localparam logic [7:0] DM_SFR_LAST = 8'h7F;
    localparam logic [7:0] DM_GP_FIRST = 8'h80;
    localparam int DM_GP_SIZE = 128;
    localparam int DM_NUM_SECTORS = 6;

    // ----------------------------------------------------------------
    // Register offsets in sector 0
    // ----------------------------------------------------------------
    localparam logic [7:0] DM_OFS_INDIRECT_PORT_SECTOR0 = 8'h00;
    localparam logic [7:0] DM_OFS_POINTER_SECTOR0 = 8'h01;
    localparam logic [7:0] DM_OFS_INDIRECT_PORT_ONE = 8'h02;
    localparam logic [7:0] DM_OFS_POINTER_ONE_LOW = 8'h03;
    localparam logic [7:0] DM_OFS_POINTER_ONE_HIGH = 8'h04;
    localparam logic [7:0] DM_OFS_INDIRECT_PORT_TWO = 8'h0C;
    localparam logic [7:0] DM_OFS_POINTER_TWO_LOW = 8'h0D;
    localparam logic [7:0] DM_OFS_POINTER_TWO_HIGH = 8'h0E;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] DM_POINTER_RESET = 8'h00;
    localparam logic [7:0] DM_READ_ZERO = 8'h00;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic [DM_ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } dm_req_type;

    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
    } dm_rsp_type;

    typedef struct packed {
        logic sel;
        logic write;
        logic [DM_ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } dm_sfr_type;

    typedef struct packed {
        logic [7:0] sector;
        logic [7:0] loc;
    } dm_target_type;

    typedef enum logic [2:0] {
        DM_KIND_ZERO,
        DM_KIND_POINTER,
        DM_KIND_RAM,
        DM_KIND_SFR
    } dm_kind_type;

endpackage

//--- dm_sfr_model.sv
// Purpose: Special register block model beside the data memory unit
// Assumes: Sector 0 holds writable registers 10H-1FH and a protected one at 0FH
// Notes:   Unmapped reads drive a nonzero pattern so a leak shows up
`timescale 1ns/1ps
module dm_sfr_model import dm_pkg::*; (
    input wire logic clk,
    input wire dm_sfr_type sfr_bus,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    output logic sfr_read_only
);
    // ----
    // Decode and storage
    // ----
    logic [7:0] store [16];
    logic rw_hit;
    assign rw_hit = sfr_bus.sel && sfr_bus.addr[10:4] == 7'h01;
    assign sfr_read_only = sfr_bus.sel && sfr_bus.addr == 11'h00F;
    assign sfr_hit = rw_hit || sfr_read_only;
    assign sfr_rdata = rw_hit ? store[sfr_bus.addr[3:0]] : (sfr_read_only ? 8'hA5 : 8'hEE);
    always_ff @(posedge clk) begin
        if (sfr_bus.write && rw_hit) begin
            store[sfr_bus.addr[3:0]] <= sfr_bus.wdata;
        end
    end
endmodule

//--- dm_unit.sv
// Purpose: Data memory access unit: decode, indirect ports, pointers, RAM
// Assumes: CPU issues at most one access per cycle; SFR block answers same cycle
// Notes:   Read data returns one cycle after the request; writes act at once
`timescale 1ns/1ps

module dm_unit
    import dm_pkg::*;
#(
    parameter int NUM_SECTORS = DM_NUM_SECTORS
) (
    input wire logic clk,
    input wire logic nrst,
    input wire dm_req_type cpu_req,
    output dm_rsp_type cpu_rsp,
    output dm_sfr_type sfr_bus,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    input wire logic sfr_read_only
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic is_port(input logic [7:0] sector, input logic [7:0] loc);
        is_port = (sector == 8'h00) && ((loc == DM_OFS_INDIRECT_PORT_SECTOR0) ||
                  (loc == DM_OFS_INDIRECT_PORT_ONE) || (loc == DM_OFS_INDIRECT_PORT_TWO));
    endfunction

    function automatic logic is_pointer(input logic [7:0] sector, input logic [7:0] loc);
        is_pointer = (sector == 8'h00) && ((loc == DM_OFS_POINTER_SECTOR0) ||
                     (loc == DM_OFS_POINTER_ONE_LOW) || (loc == DM_OFS_POINTER_ONE_HIGH) ||
                     (loc == DM_OFS_POINTER_TWO_LOW) || (loc == DM_OFS_POINTER_TWO_HIGH));
    endfunction

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0] pointer_sector0;
    logic [7:0] pointer_one_low;
    logic [7:0] pointer_one_high;
    logic [7:0] pointer_two_low;
    logic [7:0] pointer_two_high;
    logic [7:0] gp_ram [NUM_SECTORS*DM_GP_SIZE];

    dm_target_type direct;
    dm_target_type target;
    dm_kind_type kind;
    logic null_port;
    logic [31:0] ram_index;
    logic [7:0] next_rdata;
    logic wr;

    // ----------------------------------------------------------------
    // Address resolution
    // ----------------------------------------------------------------
    always_comb begin
        direct.sector = {5'b0_0000, cpu_req.addr[DM_ADDR_W-1:DM_LOC_W]};
        direct.loc = cpu_req.addr[DM_LOC_W-1:0];
        target = direct;
        if (direct.sector == 8'h00) begin
            case (direct.loc)
                DM_OFS_INDIRECT_PORT_SECTOR0: begin
                    target.sector = 8'h00;
                    target.loc = pointer_sector0;
                end
                DM_OFS_INDIRECT_PORT_ONE: begin
                    target.sector = pointer_one_high;
                    target.loc = pointer_one_low;
                end
                DM_OFS_INDIRECT_PORT_TWO: begin
                    target.sector = pointer_two_high;
                    target.loc = pointer_two_low;
                end
                default: begin
                    target = direct;
                end
            endcase
        end
    end

    always_comb begin
        null_port = is_port(target.sector, target.loc);
        ram_index = 32'(target.sector) * 32'(DM_GP_SIZE) + 32'(target.loc[6:0]);
        if (null_port) begin
            kind = DM_KIND_ZERO;
        end else if (is_pointer(target.sector, target.loc)) begin
            kind = DM_KIND_POINTER;
        end else if (target.loc >= DM_GP_FIRST) begin
            kind = (32'(target.sector) < 32'(NUM_SECTORS)) ? DM_KIND_RAM : DM_KIND_ZERO;
        end else if (32'(target.sector) < 32'(NUM_SECTORS)) begin
            kind = DM_KIND_SFR;
        end else begin
            kind = DM_KIND_ZERO;
        end
    end

    assign wr = cpu_req.valid && cpu_req.write;

    // ----------------------------------------------------------------
    // Special function register side
    // ----------------------------------------------------------------
    always_comb begin
        sfr_bus.sel = cpu_req.valid && (kind == DM_KIND_SFR);
        sfr_bus.write = wr && (kind == DM_KIND_SFR) && sfr_hit && !sfr_read_only;
        sfr_bus.addr = {target.sector[DM_SEC_W-1:0], target.loc};
        sfr_bus.wdata = cpu_req.wdata;
    end

    // ----------------------------------------------------------------
    // Read data selection
    // ----------------------------------------------------------------
    always_comb begin
        next_rdata = DM_READ_ZERO;
        case (kind)
            DM_KIND_POINTER: begin
                case (target.loc)
                    DM_OFS_POINTER_SECTOR0: next_rdata = pointer_sector0;
                    DM_OFS_POINTER_ONE_LOW: next_rdata = pointer_one_low;
                    DM_OFS_POINTER_ONE_HIGH: next_rdata = pointer_one_high;
                    DM_OFS_POINTER_TWO_LOW: next_rdata = pointer_two_low;
                    DM_OFS_POINTER_TWO_HIGH: next_rdata = pointer_two_high;
                    default: next_rdata = DM_READ_ZERO;
                endcase
            end
            DM_KIND_RAM: begin
                next_rdata = gp_ram[ram_index];
            end
            DM_KIND_SFR: begin
                next_rdata = sfr_hit ? sfr_rdata : DM_READ_ZERO;
            end
            default: begin
                next_rdata = DM_READ_ZERO;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Response register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cpu_rsp.valid <= 1'b0;
            cpu_rsp.rdata <= DM_READ_ZERO;
        end else begin
            cpu_rsp.valid <= cpu_req.valid && !cpu_req.write;
            if (cpu_req.valid && !cpu_req.write) begin
                cpu_rsp.rdata <= next_rdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Memory pointers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pointer_sector0 <= DM_POINTER_RESET;
            pointer_one_low <= DM_POINTER_RESET;
            pointer_one_high <= DM_POINTER_RESET;
            pointer_two_low <= DM_POINTER_RESET;
            pointer_two_high <= DM_POINTER_RESET;
        end else if (wr && (kind == DM_KIND_POINTER)) begin
            case (target.loc)
                DM_OFS_POINTER_SECTOR0: pointer_sector0 <= cpu_req.wdata;
                DM_OFS_POINTER_ONE_LOW: pointer_one_low <= cpu_req.wdata;
                DM_OFS_POINTER_ONE_HIGH: pointer_one_high <= cpu_req.wdata;
                DM_OFS_POINTER_TWO_LOW: pointer_two_low <= cpu_req.wdata;
                DM_OFS_POINTER_TWO_HIGH: pointer_two_high <= cpu_req.wdata;
                default: pointer_sector0 <= pointer_sector0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // General purpose RAM
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (wr && (kind == DM_KIND_RAM)) begin
            gp_ram[ram_index] <= cpu_req.wdata;
        end
    end

endmodule

//--- dm_unit_sva.sv
// Purpose: Port checker for the data memory access unit
// Assumes: One clock domain, reset active low
// Notes:   Bound to every instance of the unit
`timescale 1ns/1ps
module dm_unit_sva import dm_pkg::*; #(
    parameter int NUM_SECTORS = DM_NUM_SECTORS
) (
    input wire logic clk,
    input wire logic nrst,
    input wire dm_req_type cpu_req,
    input wire dm_rsp_type cpu_rsp,
    input wire dm_sfr_type sfr_bus,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    input wire logic sfr_read_only
);
    // ----
    // Properties
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic rd = cpu_req.valid && !cpu_req.write;
    property p_rsp_read; rd |=> cpu_rsp.valid; endproperty
    a_rsp_read: assert property (p_rsp_read) else $error("read not answered");
    property p_rsp_idle; !rd |=> !cpu_rsp.valid; endproperty
    a_rsp_idle: assert property (p_rsp_idle) else $error("answer without read");
    property p_sfr_data; rd && sfr_bus.sel && sfr_hit |=> cpu_rsp.rdata == $past(sfr_rdata); endproperty
    a_sfr_data: assert property (p_sfr_data) else $error("register data lost");
    property p_unused; rd && sfr_bus.sel && !sfr_hit |=> cpu_rsp.rdata == 8'h00; endproperty
    a_unused: assert property (p_unused) else $error("unused location not zero");
    property p_write_guard; sfr_bus.write |-> sfr_bus.sel && sfr_hit && !sfr_read_only; endproperty
    a_write_guard: assert property (p_write_guard) else $error("bad register write");
    property p_port_zero; cpu_req.valid && cpu_req.addr == 11'h000 && sfr_bus.sel
        |-> sfr_bus.addr[10:8] == 3'h0; endproperty
    a_port_zero: assert property (p_port_zero) else $error("port zero left sector 0");
    property p_ext; cpu_req.valid && cpu_req.addr[10:8] != 3'h0 && !cpu_req.addr[7]
        && cpu_req.addr[10:8] < NUM_SECTORS |-> sfr_bus.sel && sfr_bus.addr == cpu_req.addr;
    endproperty
    a_ext: assert property (p_ext) else $error("extended address misrouted");
    property p_gp_ram; cpu_req.valid && cpu_req.addr[10:7] == 4'h1 |-> !sfr_bus.sel; endproperty
    a_gp_ram: assert property (p_gp_ram) else $error("RAM decoded as register");
    property p_sector_cap; sfr_bus.sel |-> sfr_bus.addr[10:8] < NUM_SECTORS; endproperty
    a_sector_cap: assert property (p_sector_cap) else $error("missing sector selected");
    c_read: cover property (rd ##1 cpu_rsp.valid);
    c_write: cover property (sfr_bus.write);
    c_unused: cover property (rd && sfr_bus.sel && !sfr_hit);
    c_port_zero: cover property (cpu_req.valid && cpu_req.addr == 11'h000 && sfr_bus.sel);
endmodule
bind dm_unit dm_unit_sva #(.NUM_SECTORS(NUM_SECTORS)) u_dm_unit_sva (.clk(clk), .nrst(nrst),
    .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .sfr_bus(sfr_bus), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .sfr_read_only(sfr_read_only));
